// ==== common/prt_pkg.sv ====
package prt_pkg;
   // ******************************************************
   // link rates
   // ******************************************************
   localparam int RATE_GIG_HZ = 125_000_000;  // gigabit clock
   localparam int RATE_100_HZ = 25_000_000;   // 100Mbps clock
   localparam int RATE_10_HZ  = 2_500_000;    // 10Mbps clock
   localparam int SER_CLK_HZ  = 625_000_000;  // serial clock

   // ******************************************************
   // scaled half periods in ref_clk cycles
   // ******************************************************
   localparam int CNT_W = 8;                  // half period counter width
   // gigabit cannot be reached at 25MHz: smallest legal half period
   localparam logic [CNT_W-1:0] HALF_GIG = 8'h02;
   localparam logic [CNT_W-1:0] HALF_100 =
      CNT_W'(int'(HALF_GIG) * (RATE_GIG_HZ / RATE_100_HZ));
   localparam logic [CNT_W-1:0] HALF_10  =
      CNT_W'(int'(HALF_GIG) * (RATE_GIG_HZ / RATE_10_HZ));
   // serial clock shares the smallest half period
   localparam logic [CNT_W-1:0] HALF_SER =
      CNT_W'(int'(HALF_GIG) * (RATE_GIG_HZ / RATE_GIG_HZ));
   localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;

   // ******************************************************
   // words and serial framing
   // ******************************************************
   localparam int WORD_W     = 10;            // {error, valid, byte}
   localparam int BIT_DV     = 8;             // valid position
   localparam int BIT_ER     = 9;             // error position
   localparam int SER_BITS   = 11;            // start plus word
   localparam int FIFO_DEPTH = 32;            // buffer depth
   localparam logic SER_START = 1'b0;         // start bit level
   localparam logic SER_IDLE  = 1'b1;         // idle line level
   localparam logic [3:0] BITN_RST = 4'h0;
   localparam logic [WORD_W-1:0] WORD_RST = 10'h000;

   // speed selection codes
   typedef enum logic [1:0] {
      PRT_SPD_10  = 2'b00,
      PRT_SPD_100 = 2'b01,
      PRT_SPD_GIG = 2'b10
   } prt_speed_t;

   // half period of the receive clock for a speed code
   function automatic logic [CNT_W-1:0] prt_half_for(input logic [1:0] spd);
      logic [CNT_W-1:0] h;
      h = HALF_GIG;
      if (spd == PRT_SPD_10) begin
         h = HALF_10;
      end else if (spd == PRT_SPD_100) begin
         h = HALF_100;
      end
      return h;
   endfunction
endpackage

// ==== common/prt_if.sv ====
`timescale 1ns/1ps
// link pins between the transceiver and the mac
interface prt_if;
   logic xmit_nibble_bit0;           // mac to phy nibble
   logic xmit_nibble_bit1;
   logic xmit_nibble_bit2;
   logic xmit_nibble_bit3;
   logic mac_transmit_clock;         // mac made transmit clock
   logic xmit_control;               // enable / error pair
   logic recv_nibble_bit0;           // phy to mac nibble
   logic recv_nibble_bit1;
   logic recv_nibble_bit2;
   logic recv_nibble_bit3;
   logic recv_clock;                 // recovered receive clock
   logic recv_valid_error_pair;      // valid / error pair
   logic serial_in_positive;         // mac to phy serial data
   logic serial_in_negative;
   logic serial_clock_in_positive;   // mac to phy serial clock
   logic serial_clock_in_negative;
   logic serial_out_positive;        // phy to mac serial data
   logic serial_out_negative;
   logic serial_clock_out_positive;  // phy to mac serial clock
   logic serial_clock_out_negative;

   modport phy (
      input  xmit_nibble_bit0, xmit_nibble_bit1, xmit_nibble_bit2, xmit_nibble_bit3,
      input  mac_transmit_clock, xmit_control,
      input  serial_in_positive, serial_in_negative,
      input  serial_clock_in_positive, serial_clock_in_negative,
      output recv_nibble_bit0, recv_nibble_bit1, recv_nibble_bit2, recv_nibble_bit3,
      output recv_clock, recv_valid_error_pair,
      output serial_out_positive, serial_out_negative,
      output serial_clock_out_positive, serial_clock_out_negative
   );
   modport mac (
      output xmit_nibble_bit0, xmit_nibble_bit1, xmit_nibble_bit2, xmit_nibble_bit3,
      output mac_transmit_clock, xmit_control,
      output serial_in_positive, serial_in_negative,
      output serial_clock_in_positive, serial_clock_in_negative,
      input  recv_nibble_bit0, recv_nibble_bit1, recv_nibble_bit2, recv_nibble_bit3,
      input  recv_clock, recv_valid_error_pair,
      input  serial_out_positive, serial_out_negative,
      input  serial_clock_out_positive, serial_clock_out_negative
   );
endinterface

// ==== rtl/prt_phy_end.sv ====
`timescale 1ns/1ps
// ******************************************************
// word buffer with registered full and empty
// ******************************************************
module prt_fifo #(
   parameter int W     = 10,
   parameter int DEPTH = 32
) (
   input  wire logic         ref_clk,
   input  wire logic         rst,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output      logic         in_ready,
   output      logic         out_valid,
   output      logic [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem [DEPTH];       // storage
   logic [AW-1:0] wp;                // write pointer
   logic [AW-1:0] rp;                // read pointer
   logic [AW:0]   cnt;               // fill level
   logic [AW:0]   next_cnt;          // fill level after this cycle
   logic          push;
   logic          pop;

   assign push     = in_valid && in_ready;
   assign pop      = out_valid && out_ready;
   assign out_data = mem[rp];
   assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);

   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   // pointers and level
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wp  <= '0;
         rp  <= '0;
         cnt <= '0;
      end else begin
         wp  <= push ? wp + AW'(1) : wp;
         rp  <= pop ? rp + AW'(1) : rp;
         cnt <= next_cnt;
      end
   end

   // flags from the next level so they stay honest
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         in_ready  <= next_cnt != (AW+1)'(DEPTH);
         out_valid <= next_cnt != '0;
      end
   end
endmodule

// ******************************************************
// link sender: clock divider, nibble pair and serial frame
// ******************************************************
module prt_sender (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          ser_mode,
   input  wire logic [prt_pkg::CNT_W-1:0]     half,
   input  wire logic                          in_valid,
   input  wire logic [prt_pkg::WORD_W-1:0]    in_word,
   output      logic                          in_take,
   output      logic                          pclk,
   output      logic [3:0]                    nib,
   output      logic                          ctl,
   output      logic                          sclk_p,
   output      logic                          sclk_n,
   output      logic                          sdat_p,
   output      logic                          sdat_n
);
   logic [prt_pkg::CNT_W-1:0]  cnt;        // half period counter
   logic                       ph;         // link clock level
   logic                       next_ph;
   logic                       tgl;        // clock edge this cycle
   logic                       mid;        // data change point
   logic [prt_pkg::WORD_W-1:0] cur;        // word in flight
   logic [prt_pkg::WORD_W-1:0] shreg;      // serial shifter
   logic [3:0]                 bitn;       // serial bit index
   logic                       next_bit;
   logic [prt_pkg::WORD_W-1:0] w;          // word or idle

   assign tgl     = cnt >= half - prt_pkg::CNT_W'(1);
   assign mid     = cnt == (half >> 1) - prt_pkg::CNT_W'(1);
   assign next_ph = tgl ? ~ph : ph;
   assign w       = in_valid ? in_word : prt_pkg::WORD_RST;
   assign in_take = mid && !ph && in_valid && (!ser_mode || bitn == prt_pkg::BITN_RST);

   // divider
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= prt_pkg::CNT_RST;
         ph  <= 1'b0;
      end else begin
         cnt <= tgl ? prt_pkg::CNT_RST : cnt + prt_pkg::CNT_W'(1);
         ph  <= next_ph;
      end
   end

   // clocks out, only the selected mode runs
   // mode gates pins
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pclk   <= 1'b0;
         sclk_p <= 1'b0;
         sclk_n <= 1'b0;
      end else begin
         pclk   <= !ser_mode && next_ph;
         sclk_p <= ser_mode && next_ph;
         sclk_n <= ser_mode && !next_ph;
      end
   end

   // nibble pair, changed halfway between edges
   always_ff @(posedge ref_clk) begin
      if (rst || ser_mode) begin
         nib <= 4'h0;
         ctl <= 1'b0;
         cur <= prt_pkg::WORD_RST;
      end else if (mid && !ph) begin
         cur <= w;
         nib <= w[3:0];
         ctl <= w[prt_pkg::BIT_DV];
      end else if (mid) begin
         nib <= cur[7:4];
         ctl <= cur[prt_pkg::BIT_DV] ^ cur[prt_pkg::BIT_ER];
      end
   end

   // next serial bit: start, word lsb first, or idle
   always_comb begin
      next_bit = prt_pkg::SER_IDLE;
      if (bitn == prt_pkg::BITN_RST) begin
         next_bit = in_valid ? prt_pkg::SER_START : prt_pkg::SER_IDLE;
      end else begin
         next_bit = shreg[0];
      end
   end

   // serial frame, one bit per clock period, set before rise
   always_ff @(posedge ref_clk) begin
      if (rst || !ser_mode) begin
         sdat_p <= 1'b0;
         sdat_n <= 1'b0;
         bitn   <= prt_pkg::BITN_RST;
         shreg  <= prt_pkg::WORD_RST;
      end else if (mid && !ph) begin
         sdat_p <= next_bit;
         sdat_n <= ~next_bit;
         if (bitn == prt_pkg::BITN_RST) begin
            shreg <= in_word;
            bitn  <= in_valid ? 4'h1 : prt_pkg::BITN_RST;
         end else begin
            shreg <= shreg >> 1;
            bitn  <= (bitn == 4'(prt_pkg::SER_BITS - 1)) ? prt_pkg::BITN_RST : bitn + 4'h1;
         end
      end
   end
endmodule

// ******************************************************
// transceiver end of the mac link
// ******************************************************
module prt_phy_end (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          serial_mode,
   input  wire logic [1:0]                    speed_sel,
   input  wire logic [prt_pkg::WORD_W-1:0]    rx_word,
   input  wire logic                          rx_valid,
   output      logic                          rx_ready,
   output      logic [prt_pkg::WORD_W-1:0]    tx_word,
   output      logic                          tx_strobe,
   prt_if.phy                                 lnk
);
   logic [prt_pkg::WORD_W-1:0] q_word;    // buffered word
   logic                       q_valid;
   logic                       q_take;
   logic [prt_pkg::CNT_W-1:0]  half;      // receive half period
   logic [3:0]                 nib;

   assign half = serial_mode ? prt_pkg::HALF_SER : prt_pkg::prt_half_for(speed_sel);
   assign lnk.recv_nibble_bit0 = nib[0];
   assign lnk.recv_nibble_bit1 = nib[1];
   assign lnk.recv_nibble_bit2 = nib[2];
   assign lnk.recv_nibble_bit3 = nib[3];

   // words toward the mac wait here for the link
   prt_fifo #(.W(prt_pkg::WORD_W), .DEPTH(prt_pkg::FIFO_DEPTH)) u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (rx_valid),
      .in_data   (rx_word),
      .in_ready  (rx_ready),
      .out_valid (q_valid),
      .out_data  (q_word),
      .out_ready (q_take)
   );

   // receive direction driver
   prt_sender u_send (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .ser_mode (serial_mode),
      .half     (half),
      .in_valid (q_valid),
      .in_word  (q_word),
      .in_take  (q_take),
      .pclk     (lnk.recv_clock),
      .nib      (nib),
      .ctl      (lnk.recv_valid_error_pair),
      .sclk_p   (lnk.serial_clock_out_positive),
      .sclk_n   (lnk.serial_clock_out_negative),
      .sdat_p   (lnk.serial_out_positive),
      .sdat_n   (lnk.serial_out_negative)
   );

   // transmit direction sampler
   prt_receiver u_recv (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .ser_mode (serial_mode),
      .pclk_raw (lnk.mac_transmit_clock),
      .nib_raw  ({lnk.xmit_nibble_bit3, lnk.xmit_nibble_bit2,
                  lnk.xmit_nibble_bit1, lnk.xmit_nibble_bit0}),
      .ctl_raw  (lnk.xmit_control),
      .sclk_raw (lnk.serial_clock_in_positive),
      .sdat_raw (lnk.serial_in_positive),
      .o_word   (tx_word),
      .o_stb    (tx_strobe)
   );
endmodule

// ==== rtl/prt_mac_end.sv ====
`timescale 1ns/1ps
// ******************************************************
// link receiver: synchronise, find edges, rebuild words
// ******************************************************
module prt_receiver (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          ser_mode,
   input  wire logic                          pclk_raw,
   input  wire logic [3:0]                    nib_raw,
   input  wire logic                          ctl_raw,
   input  wire logic                          sclk_raw,
   input  wire logic                          sdat_raw,
   output      logic [prt_pkg::WORD_W-1:0]    o_word,
   output      logic                          o_stb
);
   logic [7:0]                 s1;        // first stage, read by s2 only
   logic [7:0]                 s2;        // second stage
   logic                       pprev;     // last parallel clock level
   logic                       sprev;     // last serial clock level
   logic [3:0]                 lo;        // low nibble from rise
   logic                       c0;        // control from rise
   logic                       busy;      // serial frame open
   logic [3:0]                 bitc;      // serial bit count
   logic [prt_pkg::WORD_W-1:0] shreg;
   logic                       rise_p;
   logic                       fall_p;
   logic                       rise_s;

   assign rise_p = s2[0] && !pprev;
   assign fall_p = !s2[0] && pprev;
   assign rise_s = s2[6] && !sprev;

   // two stage synchroniser and edge history
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s1    <= 8'h00;
         s2    <= 8'h00;
         pprev <= 1'b0;
         sprev <= 1'b0;
      end else begin
         s1    <= {sdat_raw, sclk_raw, ctl_raw, nib_raw, pclk_raw};
         s2    <= s1;
         pprev <= s2[0];
         sprev <= s2[6];
      end
   end

   // rising half of a nibble pair
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lo <= 4'h0;
         c0 <= 1'b0;
      end else if (rise_p) begin
         lo <= s2[4:1];
         c0 <= s2[5];
      end
   end

   // serial deframer, sampled on rise
   always_ff @(posedge ref_clk) begin
      if (rst || !ser_mode) begin
         busy  <= 1'b0;
         bitc  <= 4'h0;
         shreg <= prt_pkg::WORD_RST;
      end else if (rise_s && !busy) begin
         busy <= s2[7] == prt_pkg::SER_START;
         bitc <= 4'h0;
      end else if (rise_s) begin
         shreg <= {s2[7], shreg[prt_pkg::WORD_W-1:1]};
         bitc  <= bitc + 4'h1;
         busy  <= bitc != 4'(prt_pkg::WORD_W - 1);
      end
   end

   // word out, idle pairs are not reported
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         o_word <= prt_pkg::WORD_RST;
         o_stb  <= 1'b0;
      end else begin
         o_stb <= 1'b0;
         if (!ser_mode && fall_p && (c0 || s2[5])) begin
            o_word <= {c0 ^ s2[5], c0, s2[4:1], lo};
            o_stb  <= 1'b1;
         end else if (ser_mode && rise_s && busy && bitc == 4'(prt_pkg::WORD_W - 1)) begin
            o_word <= {s2[7], shreg[prt_pkg::WORD_W-1:1]};
            o_stb  <= 1'b1;
         end
      end
   end
endmodule

// ******************************************************
// mac end of the transceiver link
// ******************************************************
module prt_mac_end (
   input  wire logic                          ref_clk,
   input  wire logic                          rst,
   input  wire logic                          serial_mode,
   input  wire logic [prt_pkg::WORD_W-1:0]    tx_word,
   input  wire logic                          tx_valid,
   output      logic                          tx_ready,
   output      logic [prt_pkg::WORD_W-1:0]    rx_word,
   output      logic                          rx_strobe,
   prt_if.mac                                 lnk
);
   logic [prt_pkg::WORD_W-1:0] q_word;    // buffered word
   logic                       q_valid;
   logic                       q_take;
   logic [prt_pkg::CNT_W-1:0]  half;      // own clock half period
   logic [3:0]                 nib;

   assign half = serial_mode ? prt_pkg::HALF_SER : prt_pkg::HALF_GIG;
   assign lnk.xmit_nibble_bit0 = nib[0];
   assign lnk.xmit_nibble_bit1 = nib[1];
   assign lnk.xmit_nibble_bit2 = nib[2];
   assign lnk.xmit_nibble_bit3 = nib[3];

   // words toward the transceiver wait here
   prt_fifo #(.W(prt_pkg::WORD_W), .DEPTH(prt_pkg::FIFO_DEPTH)) u_buf (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_valid  (tx_valid),
      .in_data   (tx_word),
      .in_ready  (tx_ready),
      .out_valid (q_valid),
      .out_data  (q_word),
      .out_ready (q_take)
   );

   prt_sender u_send (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .ser_mode (serial_mode),
      .half     (half),
      .in_valid (q_valid),
      .in_word  (q_word),
      .in_take  (q_take),
      .pclk     (lnk.mac_transmit_clock),
      .nib      (nib),
      .ctl      (lnk.xmit_control),
      .sclk_p   (lnk.serial_clock_in_positive),
      .sclk_n   (lnk.serial_clock_in_negative),
      .sdat_p   (lnk.serial_in_positive),
      .sdat_n   (lnk.serial_in_negative)
   );

   prt_receiver u_recv (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .ser_mode (serial_mode),
      .pclk_raw (lnk.recv_clock),
      .nib_raw  ({lnk.recv_nibble_bit3, lnk.recv_nibble_bit2,
                  lnk.recv_nibble_bit1, lnk.recv_nibble_bit0}),
      .ctl_raw  (lnk.recv_valid_error_pair),
      .sclk_raw (lnk.serial_clock_out_positive),
      .sdat_raw (lnk.serial_out_positive),
      .o_word   (rx_word),
      .o_stb    (rx_strobe)
   );
endmodule

// ==== dv/prt_link_assertions.sv ====
`timescale 1ns/1ps
// ******************************************************
// link checker beside the shared interface
// ******************************************************
module prt_link_assertions (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       serial_mode,
   input wire logic [1:0] speed_sel,
   input wire logic       mac_transmit_clock,
   input wire logic       xmit_control,
   input wire logic       xmit_nibble_bit0,
   input wire logic       xmit_nibble_bit3,
   input wire logic       recv_clock,
   input wire logic       recv_valid_error_pair,
   input wire logic       recv_nibble_bit0,
   input wire logic       recv_nibble_bit3,
   input wire logic       serial_clock_out_positive,
   input wire logic       serial_out_positive,
   input wire logic       serial_clock_in_positive,
   input wire logic       serial_in_positive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [prt_pkg::CNT_W-1:0] rc_cnt;   // samples since last receive clock change
   logic [prt_pkg::CNT_W-1:0] rc_half;  // expected half period for the speed
   logic                      rc_last;  // receive clock one sample ago
   logic                      rc_seen;  // a full half period has started
   assign rc_half = (speed_sel == 2'h0) ? prt_pkg::HALF_10 :
                    (speed_sel == 2'h1) ? prt_pkg::HALF_100 : prt_pkg::HALF_GIG;
   // measure each receive clock half period
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rc_cnt  <= 8'h00;
         rc_seen <= 1'b0;
      end else if (recv_clock != rc_last) begin
         rc_cnt  <= 8'h01;
         rc_seen <= 1'b1;
      end else begin
         rc_cnt  <= rc_cnt + 8'h01;
      end
   end
   // remember the previous receive clock level
   always_ff @(posedge ref_clk) begin
      rc_last <= rst ? 1'b0 : recv_clock;
   end
   property p_rx_rate;
      !serial_mode && rc_seen && (recv_clock != rc_last) |-> rc_cnt == rc_half;
   endproperty
   a_rx_rate: assert property (p_rx_rate) else $error("receive clock rate wrong");
   property p_rx_sync;
      !serial_mode && $changed(recv_clock) |->
         $stable({recv_nibble_bit3, recv_nibble_bit0, recv_valid_error_pair});
   endproperty
   a_rx_sync: assert property (p_rx_sync) else $error("receive pins move at edge");
   property p_tx_sync;
      !serial_mode && $changed(mac_transmit_clock) |->
         $stable({xmit_nibble_bit3, xmit_nibble_bit0, xmit_control});
   endproperty
   a_tx_sync: assert property (p_tx_sync) else $error("transmit pins move at edge");
   property p_tx_clk;
      !serial_mode && $rose(mac_transmit_clock) |-> ##1 mac_transmit_clock
         ##1 !mac_transmit_clock ##1 !mac_transmit_clock ##1 mac_transmit_clock;
   endproperty
   a_tx_clk: assert property (p_tx_clk) else $error("transmit clock not steady");
   property p_ser_clk;
      serial_mode && $rose(serial_clock_out_positive) |-> ##1 serial_clock_out_positive
         ##1 !serial_clock_out_positive ##1 !serial_clock_out_positive
         ##1 serial_clock_out_positive;
   endproperty
   a_ser_clk: assert property (p_ser_clk) else $error("serial clock not steady");
   property p_ser_rx;
      $rose(serial_clock_out_positive) |-> $stable(serial_out_positive);
   endproperty
   a_ser_rx: assert property (p_ser_rx) else $error("serial out moves at edge");
   property p_ser_tx;
      $rose(serial_clock_in_positive) |-> $stable(serial_in_positive);
   endproperty
   a_ser_tx: assert property (p_ser_tx) else $error("serial in moves at edge");
   property p_par_quiet;
      serial_mode |-> !recv_clock && !recv_valid_error_pair && !recv_nibble_bit0;
   endproperty
   a_par_quiet: assert property (p_par_quiet) else $error("parallel pins active");
   property p_ser_quiet;
      !serial_mode |-> !serial_clock_out_positive && !serial_out_positive;
   endproperty
   a_ser_quiet: assert property (p_ser_quiet) else $error("serial pins active");
endmodule

// ==== dv/prt_phy_mac_tb.sv ====
`timescale 1ns/1ps
// ******************************************************
// both link ends face to face
// ******************************************************
module prt_phy_mac_tb;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       serial_mode = 1'b0;
   logic [1:0] speed_sel = 2'h2;
   logic [9:0] p_word = 10'h000, m_word = 10'h000, p_got, m_got;
   logic       p_valid = 1'b0, m_valid = 1'b0, p_ready, m_ready, p_stb, m_stb;
   logic       saw_full = 1'b0;
   logic [9:0] q_mac[$], q_phy[$], ws[5] = '{10'h1A5, 10'h35A, 10'h000, 10'h1FF, 10'h300};
   int         n_mismatch = 0, check_count = 0;
   prt_if lnk();
   prt_phy_end u_prt_phy_end (.ref_clk(ref_clk), .rst(rst), .serial_mode(serial_mode),
      .speed_sel(speed_sel), .rx_word(p_word), .rx_valid(p_valid), .rx_ready(p_ready),
      .tx_word(p_got), .tx_strobe(p_stb), .lnk(lnk));
   prt_mac_end u_prt_mac_end (.ref_clk(ref_clk), .rst(rst), .serial_mode(serial_mode),
      .tx_word(m_word), .tx_valid(m_valid), .tx_ready(m_ready),
      .rx_word(m_got), .rx_strobe(m_stb), .lnk(lnk));
   prt_link_assertions u_prt_link_assertions (.ref_clk(ref_clk), .rst(rst),
      .serial_mode(serial_mode), .speed_sel(speed_sel),
      .mac_transmit_clock(lnk.mac_transmit_clock), .xmit_control(lnk.xmit_control),
      .xmit_nibble_bit0(lnk.xmit_nibble_bit0), .xmit_nibble_bit3(lnk.xmit_nibble_bit3),
      .recv_clock(lnk.recv_clock), .recv_valid_error_pair(lnk.recv_valid_error_pair),
      .recv_nibble_bit0(lnk.recv_nibble_bit0), .recv_nibble_bit3(lnk.recv_nibble_bit3),
      .serial_clock_out_positive(lnk.serial_clock_out_positive),
      .serial_out_positive(lnk.serial_out_positive),
      .serial_clock_in_positive(lnk.serial_clock_in_positive),
      .serial_in_positive(lnk.serial_in_positive));
   // 25MHz clock
   always #20 ref_clk = ~ref_clk;
   // compare and count
   task automatic check(input logic [9:0] got, input logic [9:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t word %h expected %h", $time, got, exp);
      end
   endtask
   // print counts and verdict, then stop
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // offer one word at one end, held until ready is seen
   task automatic put(input bit to_mac, input logic [9:0] w);
      int n;
      n = 0;
      p_word  <= w;
      m_word  <= w;
      p_valid <= to_mac;
      m_valid <= !to_mac;
      // serial frames carry idle words too, parallel idle pairs give no strobe
      if (w[9:8] != 2'h0 || serial_mode) begin
         if (to_mac) q_mac.push_back(w);
         else q_phy.push_back(w);
      end
      // ready is read mid cycle where it has settled, the word goes at the next rise
      do begin
         @(negedge ref_clk);
         n++;
      end while (((to_mac ? p_ready : m_ready) !== 1'b1) && n < 5000);
      @(posedge ref_clk);
   endtask
   // drop both offers, wait for the link to empty, restart in a mode
   task automatic next_mode(input logic ser, input logic [1:0] spd);
      int n;
      p_valid <= 1'b0;
      m_valid <= 1'b0;
      for (n = 0; n < 20000 && (q_mac.size() + q_phy.size()) != 0; n++) @(posedge ref_clk);
      repeat (300) @(posedge ref_clk);
      check(10'(q_mac.size() + q_phy.size()), 10'h000);
      rst <= 1'b1;
      serial_mode <= ser;
      speed_sel <= spd;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
   endtask
   // receiving ends against the sent order, read mid cycle so each strobe is seen once
   always @(negedge ref_clk) begin
      if (m_stb === 1'b1) check(m_got, q_mac.size() ? q_mac.pop_front() : ~m_got);
      if (p_stb === 1'b1) check(p_got, q_phy.size() ? q_phy.pop_front() : ~p_got);
      if (!rst && p_ready === 1'b0) saw_full <= 1'b1;
   end
   // cut a hang short
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_mismatch++;
      give_verdict();
   end
   // main sequence: gig, 100M, serial, gig by spare code, 10M with a full buffer
   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      for (int m = 0; m < 5; m++) begin
         foreach (ws[i]) begin
            put(1'b1, ws[i]);
            put(1'b0, ws[i] ^ 10'h0FF);
         end
         if (m == 0) next_mode(1'b0, 2'h1);
         if (m == 1) next_mode(1'b1, 2'h0);
         if (m == 2) next_mode(1'b0, 2'h3);
         if (m == 3) next_mode(1'b0, 2'h0);
      end
      for (int i = 0; i < 40; i++) put(1'b1, 10'h100 | 10'(i));
      next_mode(1'b0, 2'h2);
      check({9'h000, saw_full}, 10'h001);
      give_verdict();
   end
endmodule
